// >>> common/lut_pkg.sv
package lut_pkg;
  localparam int NPTS = 11;
  localparam int LAST_PT = 10;
  localparam int VW = 16;
  localparam int AW = 8;
  localparam int CTRL_W = 13;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RANGE = 8'h08;
  localparam logic [7:0] OFS_OUT = 8'h0C;
  localparam logic [1:0] REGION_MISC = 2'h0;
  localparam logic [1:0] REGION_X = 2'h1;
  localparam logic [1:0] REGION_Y = 2'h2;
  localparam logic [1:0] REGION_RESP = 2'h3;
  localparam logic [3:0] SRC_NOT_USED = 4'h0;
  localparam logic [1:0] DEC_MAX = 2'h2;
  localparam int Y_STEP_PCT = 10;
  localparam int X_DEF_STEPS = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {PT_RAMP = 2'h0, PT_STEP = 2'h1, PT_IGNORE = 2'h2} pt_resp_t;
  typedef struct packed {
    logic [1:0] y_dec;
    logic [1:0] x_dec;
    logic time_axis;
    logic [3:0] inst;
    logic [3:0] src;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 13'h0000;
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } axi_rsp_t;
  localparam axi_rsp_t AXI_RSP_RESET = 41'h000_0000_0000;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WRITE = 5'h02,
    ST_BRESP = 5'h04,
    ST_READ = 5'h08,
    ST_RRESP = 5'h10
  } bus_state_t;
endpackage

// >>> rtl/piecewise_lookup_table.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module piecewise_lookup_table (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lut_pkg::AW-1:0] axi_awaddr,
  input wire logic axi_awvalid,
  output logic axi_awready,
  input wire logic [31:0] axi_wdata,
  input wire logic [3:0] axi_wstrb,
  input wire logic axi_wvalid,
  output logic axi_wready,
  output logic [1:0] axi_bresp,
  output logic axi_bvalid,
  input wire logic axi_bready,
  input wire logic [lut_pkg::AW-1:0] axi_araddr,
  input wire logic axi_arvalid,
  output logic axi_arready,
  output logic [31:0] axi_rdata,
  output logic [1:0] axi_rresp,
  output logic axi_rvalid,
  input wire logic axi_rready,
  input wire logic signed [lut_pkg::VW-1:0] in_value,
  input wire logic signed [lut_pkg::VW-1:0] input_floor,
  input wire logic signed [lut_pkg::VW-1:0] input_ceiling,
  output logic signed [lut_pkg::VW-1:0] table_out,
  output logic signed [lut_pkg::VW-1:0] output_floor,
  output logic signed [lut_pkg::VW-1:0] output_ceiling,
  output logic table_enabled
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int pow10(input logic [1:0] d);
    case (d)
      2'h0: pow10 = 32'h0000_0001;
      2'h1: pow10 = 32'h0000_000A;
      default: pow10 = 32'h0000_0064;
    endcase
  endfunction

  function automatic logic signed [15:0] rescale(input logic signed [15:0] v, input logic [1:0] from,
                                                 input logic [1:0] to);
    logic signed [31:0] w;
    w = 32'(v);
    if (to >= from)
    begin
      w = 32'(w * pow10(2'(to - from)));
    end
    else
    begin
      w = w / pow10(2'(from - to));
    end
    rescale = 16'(w);
  endfunction

  function automatic logic [3:0] pt_index(input logic [7:0] a);
    pt_index = a[5:2];
  endfunction

  function automatic logic pt_valid(input logic [7:0] a);
    pt_valid = (a[5:2] < 4'(lut_pkg::NPTS));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  lut_pkg::bus_state_t state, next_state;
  lut_pkg::axi_rsp_t rsp, next_rsp;
  lut_pkg::ctrl_t ctrl, next_ctrl;
  logic signed [lut_pkg::VW-1:0] px [lut_pkg::NPTS];
  logic signed [lut_pkg::VW-1:0] py [lut_pkg::NPTS];
  lut_pkg::pt_resp_t pr [lut_pkg::NPTS];
  logic signed [lut_pkg::VW-1:0] next_px [lut_pkg::NPTS];
  logic signed [lut_pkg::VW-1:0] next_py [lut_pkg::NPTS];
  lut_pkg::pt_resp_t next_pr [lut_pkg::NPTS];
  logic signed [lut_pkg::VW-1:0] next_out, next_floor, next_ceiling;
  logic next_enabled;

  logic [3:0] last, seg, prev, wi;
  logic hit, order_ok, active, x_fits;
  logic signed [lut_pkg::VW-1:0] lo, hi, yv, xv, x_low, x_high;
  logic signed [31:0] dx, dy, din;
  logic signed [47:0] num;
  logic [31:0] wd;
  lut_pkg::ctrl_t c;

  assign axi_awready = rsp.awready;
  assign axi_wready = rsp.wready;
  assign axi_arready = rsp.arready;
  assign axi_bvalid = rsp.bvalid;
  assign axi_bresp = rsp.bresp;
  assign axi_rvalid = rsp.rvalid;
  assign axi_rresp = rsp.rresp;
  assign axi_rdata = rsp.rdata;

  // ----------------------------------------
  // Evaluation of the table
  // ----------------------------------------
  always_comb
  begin
    last = 4'(lut_pkg::LAST_PT);
    for (int i = lut_pkg::LAST_PT; i >= 1; i--)
    begin
      if (pr[i] == lut_pkg::PT_IGNORE)
      begin
        last = 4'(i - 1);
      end
    end
    lo = py[0];
    hi = py[0];
    order_ok = (px[0] >= input_floor);
    for (int i = 1; i < lut_pkg::NPTS; i++)
    begin
      if (4'(i) <= last)
      begin
        if (py[i] < lo)
        begin
          lo = py[i];
        end
        if (py[i] > hi)
        begin
          hi = py[i];
        end
        if (px[i] < px[i-1])
        begin
          order_ok = 1'b0;
        end
      end
    end
    if (px[last] > input_ceiling)
    begin
      order_ok = 1'b0;
    end
    seg = 4'h0;
    hit = 1'b0;
    for (int k = 1; k < lut_pkg::NPTS; k++)
    begin
      if (!hit && 4'(k) <= last && in_value <= px[k])
      begin
        seg = 4'(k);
        hit = 1'b1;
      end
    end
    prev = hit ? 4'(seg - 4'h1) : 4'h0;
    dx = 32'(px[seg]) - 32'(px[prev]);
    dy = 32'(py[seg]) - 32'(py[prev]);
    din = 32'(in_value) - 32'(px[prev]);
    num = 48'(dy) * 48'(din);
    if (in_value < px[0])
    begin
      yv = py[0];
    end
    else if (!hit)
    begin
      yv = py[last];
    end
    else if (pr[seg] == lut_pkg::PT_STEP || dx == 32'h0000_0000)
    begin
      yv = py[seg];
    end
    else
    begin
      yv = 16'(48'(py[prev]) + num / 48'(dx));
    end
    active = (ctrl.src != lut_pkg::SRC_NOT_USED) && !ctrl.time_axis;
    next_enabled = active;
    next_out = active ? yv : 16'h0000;
    next_floor = active ? lo : 16'h0000;
    next_ceiling = active ? hi : 16'h0000;
  end

  // Floor and ceiling feed the consumer's linear scaling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      table_out <= 16'h0000;
      output_floor <= 16'h0000;
      output_ceiling <= 16'h0000;
      table_enabled <= 1'b0;
    end
    else
    begin
      table_out <= next_out;
      output_floor <= next_floor;
      output_ceiling <= next_ceiling;
      table_enabled <= next_enabled;
    end
  end

  // ----------------------------------------
  // Register bus and table storage
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_rsp = rsp;
    next_ctrl = ctrl;
    next_px = px;
    next_py = py;
    next_pr = pr;
    wi = pt_index(axi_awaddr);
    wd = merge((axi_awaddr[7:6] == lut_pkg::REGION_Y) ? {{16{py[wi][15]}}, py[wi]} :
               (axi_awaddr[7:6] == lut_pkg::REGION_RESP) ? 32'(pr[wi]) : {{16{px[wi][15]}}, px[wi]},
               axi_wdata, axi_wstrb);
    xv = 16'(wd);
    x_low = (wi == 4'h0) ? input_floor : px[4'(wi - 4'h1)];
    x_high = (wi < last) ? px[4'(wi + 4'h1)] : input_ceiling;
    x_fits = (wi > last) || (xv >= x_low && xv <= x_high && xv >= input_floor && xv <= input_ceiling);
    c = lut_pkg::ctrl_t'(13'(merge(32'(ctrl), axi_wdata, axi_wstrb)));
    if (c.x_dec > lut_pkg::DEC_MAX)
    begin
      c.x_dec = lut_pkg::DEC_MAX;
    end
    if (c.y_dec > lut_pkg::DEC_MAX)
    begin
      c.y_dec = lut_pkg::DEC_MAX;
    end
    case (state)
      lut_pkg::ST_IDLE:
      begin
        if (axi_awvalid && axi_wvalid)
        begin
          next_state = lut_pkg::ST_WRITE;
          next_rsp.awready = 1'b1;
          next_rsp.wready = 1'b1;
        end
        else if (axi_arvalid)
        begin
          next_state = lut_pkg::ST_READ;
          next_rsp.arready = 1'b1;
        end
      end
      lut_pkg::ST_WRITE:
      begin
        next_state = lut_pkg::ST_BRESP;
        next_rsp.awready = 1'b0;
        next_rsp.wready = 1'b0;
        next_rsp.bvalid = 1'b1;
        next_rsp.bresp = lut_pkg::RESP_OKAY;
        case (axi_awaddr[7:6])
          lut_pkg::REGION_MISC:
          begin
            if (axi_awaddr == lut_pkg::OFS_CTRL)
            begin
              next_ctrl = c;
              for (int i = 0; i < lut_pkg::NPTS; i++)
              begin
                next_px[i] = rescale(px[i], ctrl.x_dec, c.x_dec);
                next_py[i] = rescale(py[i], ctrl.y_dec, c.y_dec);
              end
              if (c.src != ctrl.src || c.inst != ctrl.inst || c.time_axis != ctrl.time_axis)
              begin
                for (int i = 0; i < lut_pkg::NPTS; i++)
                begin
                  next_pr[i] = lut_pkg::PT_RAMP;
                  next_py[i] = 16'(i * lut_pkg::Y_STEP_PCT * pow10(c.y_dec));
                  if (i == 0)
                  begin
                    next_px[i] = (input_floor < 0) ? input_floor : 16'h0000;
                  end
                  else
                  begin
                    next_px[i] = 16'(32'(input_floor) + (32'(input_ceiling) - 32'(input_floor)) * (i - 1)
                                     / lut_pkg::X_DEF_STEPS);
                  end
                end
              end
            end
            else if (axi_awaddr == lut_pkg::OFS_STATUS || axi_awaddr == lut_pkg::OFS_RANGE ||
                     axi_awaddr == lut_pkg::OFS_OUT)
            begin
              next_rsp.bresp = lut_pkg::RESP_SLVERR;
            end
            else
            begin
              next_rsp.bresp = lut_pkg::RESP_DECERR;
            end
          end
          lut_pkg::REGION_X:
          begin
            if (!pt_valid(axi_awaddr))
            begin
              next_rsp.bresp = lut_pkg::RESP_DECERR;
            end
            else if (!x_fits)
            begin
              next_rsp.bresp = lut_pkg::RESP_SLVERR;
            end
            else
            begin
              next_px[wi] = xv;
            end
          end
          lut_pkg::REGION_Y:
          begin
            if (!pt_valid(axi_awaddr))
            begin
              next_rsp.bresp = lut_pkg::RESP_DECERR;
            end
            else
            begin
              next_py[wi] = 16'(wd);
            end
          end
          default:
          begin
            if (!pt_valid(axi_awaddr))
            begin
              next_rsp.bresp = lut_pkg::RESP_DECERR;
            end
            else if (wd[1:0] == 2'h3 || (wi == 4'h0 && wd[1:0] == lut_pkg::PT_IGNORE))
            begin
              next_rsp.bresp = lut_pkg::RESP_SLVERR;
            end
            else
            begin
              next_pr[wi] = lut_pkg::pt_resp_t'(wd[1:0]);
            end
          end
        endcase
      end
      lut_pkg::ST_BRESP:
      begin
        if (axi_bready)
        begin
          next_rsp.bvalid = 1'b0;
          next_state = lut_pkg::ST_IDLE;
        end
      end
      lut_pkg::ST_READ:
      begin
        next_state = lut_pkg::ST_RRESP;
        next_rsp.arready = 1'b0;
        next_rsp.rvalid = 1'b1;
        next_rsp.rresp = lut_pkg::RESP_OKAY;
        next_rsp.rdata = 32'h0000_0000;
        if (axi_araddr[7:6] != lut_pkg::REGION_MISC && !pt_valid(axi_araddr))
        begin
          next_rsp.rresp = lut_pkg::RESP_DECERR;
        end
        else
        begin
          case (axi_araddr[7:6])
            lut_pkg::REGION_MISC:
            begin
              case (axi_araddr)
                lut_pkg::OFS_CTRL: next_rsp.rdata = 32'(ctrl);
                lut_pkg::OFS_STATUS: next_rsp.rdata = 32'({order_ok, last, table_enabled});
                lut_pkg::OFS_RANGE: next_rsp.rdata = {output_ceiling, output_floor};
                lut_pkg::OFS_OUT: next_rsp.rdata = {{16{table_out[15]}}, table_out};
                default: next_rsp.rresp = lut_pkg::RESP_DECERR;
              endcase
            end
            lut_pkg::REGION_X: next_rsp.rdata = {{16{px[pt_index(axi_araddr)][15]}}, px[pt_index(axi_araddr)]};
            lut_pkg::REGION_Y: next_rsp.rdata = {{16{py[pt_index(axi_araddr)][15]}}, py[pt_index(axi_araddr)]};
            default: next_rsp.rdata = 32'(pr[pt_index(axi_araddr)]);
          endcase
        end
      end
      lut_pkg::ST_RRESP:
      begin
        if (axi_rready)
        begin
          next_rsp.rvalid = 1'b0;
          next_state = lut_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = lut_pkg::ST_IDLE;
        next_rsp = lut_pkg::AXI_RSP_RESET;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= lut_pkg::ST_IDLE;
      rsp <= lut_pkg::AXI_RSP_RESET;
      ctrl <= lut_pkg::CTRL_RESET;
      for (int i = 0; i < lut_pkg::NPTS; i++)
      begin
        px[i] <= 16'h0000;
        py[i] <= 16'h0000;
        pr[i] <= lut_pkg::PT_RAMP;
      end
    end
    else
    begin
      state <= next_state;
      rsp <= next_rsp;
      ctrl <= next_ctrl;
      px <= next_px;
      py <= next_py;
      pr <= next_pr;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_disabled: assert property ($rose(aresetn) |-> ctrl.src == lut_pkg::SRC_NOT_USED && !table_enabled)
    else $error("table not disabled after reset");
  chk_default_load: assert property ($past(aresetn) && $changed({ctrl.src, ctrl.inst}) |->
      px[1] == $past(input_floor) && pr[1] == lut_pkg::PT_RAMP &&
      py[lut_pkg::LAST_PT] == 16'(lut_pkg::LAST_PT * lut_pkg::Y_STEP_PCT * pow10(ctrl.y_dec)))
    else $error("defaults not loaded on source change");
  chk_axis_reload: assert property ($past(aresetn) && $changed(ctrl.time_axis) |->
      py[0] == 16'h0000 && pr[lut_pkg::LAST_PT] == lut_pkg::PT_RAMP && px[lut_pkg::LAST_PT] == $past(input_ceiling))
    else $error("axis type change did not reload defaults");
  chk_x_reject: assert property (state == lut_pkg::ST_WRITE && axi_awaddr[7:6] == lut_pkg::REGION_X &&
      pt_valid(axi_awaddr) && !x_fits |=> rsp.bvalid && rsp.bresp == lut_pkg::RESP_SLVERR)
    else $error("out of order X value accepted");
  chk_x_rescale: assert property ($past(aresetn) && $changed(ctrl.x_dec) &&
      $stable({ctrl.src, ctrl.inst, ctrl.time_axis}) |->
      px[lut_pkg::LAST_PT] == rescale($past(px[lut_pkg::LAST_PT]), $past(ctrl.x_dec), ctrl.x_dec))
    else $error("X values not rescaled");
  chk_range_order: assert property (table_enabled |-> output_floor <= output_ceiling)
    else $error("output floor above ceiling");
  chk_below_first: assert property (active && in_value < px[0] |=> table_out == $past(py[0]))
    else $error("input below first point not clamped");
  chk_step_resp: assert property (active && hit && in_value >= px[0] && pr[seg] == lut_pkg::PT_STEP |=>
      table_out == $past(py[seg]))
    else $error("step response wrong");
  chk_flat_segment: assert property (active && hit && in_value >= px[0] && dx == 32'h0000_0000 |=>
      table_out == $past(py[seg]))
    else $error("flat segment wrong");
  chk_ignore_hold: assert property (active && !hit && in_value >= px[0] |=> table_out == $past(py[last]))
    else $error("ignored tail not held");
  chk_write_answer: assert property (state == lut_pkg::ST_WRITE |=> rsp.bvalid)
    else $error("write not answered");

endmodule

// >>> verif/lut_partner.sv
`timescale 1ns/1ps
module lut_partner (
  input wire logic signed [15:0] want_value,
  input wire logic signed [15:0] want_floor,
  input wire logic signed [15:0] want_ceil,
  input wire logic signed [lut_pkg::VW-1:0] table_out,
  input wire logic signed [lut_pkg::VW-1:0] output_floor,
  input wire logic signed [lut_pkg::VW-1:0] output_ceiling,
  output logic signed [lut_pkg::VW-1:0] in_value,
  output logic signed [lut_pkg::VW-1:0] input_floor,
  output logic signed [lut_pkg::VW-1:0] input_ceiling,
  output logic [31:0] permille
);
  int span;
  int offs;

  // ------------------------------------------------
  // Source side: value and its operating range
  // ------------------------------------------------
  assign in_value = want_value;
  assign input_floor = want_floor;
  assign input_ceiling = want_ceil;

  // ------------------------------------------------
  // Consumer side: scale onto 0..1000 from the range limits
  // ------------------------------------------------
  always_comb
  begin
    span = int'(output_ceiling) - int'(output_floor);
    offs = int'(table_out) - int'(output_floor);
    if (span == 0)
      permille = '0;
    else
      permille = 32'(offs * 1000 / span);
  end
endmodule

// >>> verif/piecewise_lookup_table_tb.sv
`timescale 1ns/1ps
module piecewise_lookup_table_tb;
  logic aclk, aresetn, table_enabled;
  logic axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready;
  logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
  logic [7:0] axi_awaddr, axi_araddr;
  logic [31:0] axi_wdata, axi_rdata, permille, rd_data;
  logic [3:0] axi_wstrb;
  logic [1:0] axi_bresp, axi_rresp;
  logic signed [15:0] want_value, want_floor, want_ceil, in_value, input_floor, input_ceiling;
  logic signed [15:0] table_out, output_floor, output_ceiling;
  int err_total, total_checks, cyc;
  int rows[6][2] = '{'{-50, 0}, '{0, 0}, '{155, 15}, '{999, 99}, '{1000, 100}, '{2000, 100}};

  piecewise_lookup_table dut (.aclk(aclk), .aresetn(aresetn), .axi_awaddr(axi_awaddr),
    .axi_awvalid(axi_awvalid), .axi_awready(axi_awready), .axi_wdata(axi_wdata), .axi_wstrb(axi_wstrb),
    .axi_wvalid(axi_wvalid), .axi_wready(axi_wready), .axi_bresp(axi_bresp), .axi_bvalid(axi_bvalid),
    .axi_bready(axi_bready), .axi_araddr(axi_araddr), .axi_arvalid(axi_arvalid), .axi_arready(axi_arready),
    .axi_rdata(axi_rdata), .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid), .axi_rready(axi_rready),
    .in_value(in_value), .input_floor(input_floor), .input_ceiling(input_ceiling), .table_out(table_out),
    .output_floor(output_floor), .output_ceiling(output_ceiling), .table_enabled(table_enabled));

  lut_partner partner (.want_value(want_value), .want_floor(want_floor), .want_ceil(want_ceil),
    .table_out(table_out), .output_floor(output_floor), .output_ceiling(output_ceiling),
    .in_value(in_value), .input_floor(input_floor), .input_ceiling(input_ceiling), .permille(permille));

  // ------------------------------------------------
  // Clock and run limit
  // ------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge aclk);
      cyc++;
      if (cyc > 20000)
      begin
        err_total++;
        test_done();
      end
    end
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    axi_awaddr <= a;
    axi_wdata <= d;
    axi_awvalid <= 1'b1;
    axi_wvalid <= 1'b1;
    axi_bready <= 1'b1;
    do @(posedge aclk); while (axi_awready !== 1'b1);
    chk("wready", 32'(axi_wready), 32'h0000_0001);
    axi_awvalid <= 1'b0;
    axi_wvalid <= 1'b0;
    do @(posedge aclk); while (axi_bvalid !== 1'b1);
    axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), 32'(axi_bresp), 32'(exp));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] exp, output logic [31:0] d);
    axi_araddr <= a;
    axi_arvalid <= 1'b1;
    axi_rready <= 1'b1;
    do @(posedge aclk); while (axi_arready !== 1'b1);
    axi_arvalid <= 1'b0;
    do @(posedge aclk); while (axi_rvalid !== 1'b1);
    axi_rready <= 1'b0;
    d = axi_rdata;
    chk($sformatf("rresp %h", a), 32'(axi_rresp), 32'(exp));
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, lut_pkg::RESP_OKAY, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    err_total = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready} = 5'h00;
    axi_awaddr = 8'h00;
    axi_araddr = 8'h00;
    axi_wdata = 32'h0000_0000;
    axi_wstrb = 4'hF;
    want_value = 16'h0000;
    want_floor = 16'h0000;
    want_ceil = 16'h0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("table_enabled", 32'(table_enabled), 32'h0000_0000);
    rdc(lut_pkg::OFS_CTRL, 32'h0000_0000);
    want_floor <= 16'h0064;
    want_ceil <= 16'h03E8;
    wr(lut_pkg::OFS_CTRL, 32'h0000_0001, lut_pkg::RESP_OKAY);
    rdc(8'h40, 32'h0000_0000);
    rdc(8'h44, 32'h0000_0064);
    rdc(8'h68, 32'h0000_03E8);
    rdc(8'hA8, 32'h0000_0064);
    rdc(8'h94, 32'h0000_0032);
    rdc(8'hC4, 32'h0000_0000);
    settle();
    chk("output_floor", 32'(output_floor), 32'h0000_0000);
    chk("output_ceiling", 32'(output_ceiling), 32'h0000_0064);
    foreach (rows[i])
    begin
      want_value <= 16'(rows[i][0]);
      settle();
      chk($sformatf("table_out %0d", rows[i][0]), 32'(table_out), 32'(rows[i][1]));
    end
    want_value <= 16'h009B;
    settle();
    chk("permille", permille, 32'h0000_0096);
    wr(8'hCC, 32'h0000_0001, lut_pkg::RESP_OKAY);
    want_value <= 16'h00FA;
    settle();
    chk("table_out step", 32'(table_out), 32'h0000_001E);
    wr(8'h48, 32'h0000_0032, lut_pkg::RESP_SLVERR);
    rdc(8'h48, 32'h0000_00C8);
    wr(8'h68, 32'h0000_03E9, lut_pkg::RESP_SLVERR);
    wr(8'h68, 32'h0000_03B6, lut_pkg::RESP_OKAY);
    wr(8'h64, 32'h0000_0352, lut_pkg::RESP_OKAY);
    wr(8'hC0, 32'h0000_0002, lut_pkg::RESP_SLVERR);
    wr(8'hC4, 32'h0000_0003, lut_pkg::RESP_SLVERR);
    wr(8'hD4, 32'h0000_0002, lut_pkg::RESP_OKAY);
    want_value <= 16'h0384;
    settle();
    chk("table_out ignore", 32'(table_out), 32'h0000_0028);
    chk("output_ceiling", 32'(output_ceiling), 32'h0000_0028);
    wr(8'h5C, 32'h0000_000A, lut_pkg::RESP_OKAY);
    rd(lut_pkg::OFS_STATUS, lut_pkg::RESP_OKAY, rd_data);
    chk("status", 32'(rd_data[4:0]), 32'h0000_0009);
    wr(lut_pkg::OFS_STATUS, 32'h0000_0000, lut_pkg::RESP_SLVERR);
    rd(8'h6C, lut_pkg::RESP_DECERR, rd_data);
    chk("unmapped", rd_data, 32'h0000_0000);
    wr(lut_pkg::OFS_CTRL, 32'h0000_1A01, lut_pkg::RESP_OKAY);
    rdc(lut_pkg::OFS_CTRL, 32'h0000_1201);
    rdc(8'h44, 32'h0000_03E8);
    rdc(8'h90, 32'h0000_0FA0);
    settle();
    chk("output_ceiling", 32'(output_ceiling), 32'h0000_0FA0);
    want_floor <= 16'hFFD8;
    want_ceil <= 16'h035C;
    wr(lut_pkg::OFS_CTRL, 32'h0000_0002, lut_pkg::RESP_OKAY);
    rdc(8'h40, 32'hFFFF_FFD8);
    rdc(8'h44, 32'hFFFF_FFD8);
    rdc(8'h68, 32'h0000_035C);
    rdc(8'hD4, 32'h0000_0000);
    want_value <= 16'hFFD8;
    settle();
    chk("table_out flat", 32'(table_out), 32'h0000_000A);
    wr(8'hA8, 32'h0000_004D, lut_pkg::RESP_OKAY);
    wr(lut_pkg::OFS_CTRL, 32'h0000_0012, lut_pkg::RESP_OKAY);
    rdc(8'hA8, 32'h0000_0064);
    wr(8'hA8, 32'h0000_004D, lut_pkg::RESP_OKAY);
    wr(lut_pkg::OFS_CTRL, 32'h0000_0112, lut_pkg::RESP_OKAY);
    rdc(8'hA8, 32'h0000_0064);
    settle();
    chk("table_enabled", 32'(table_enabled), 32'h0000_0000);
    chk("table_out time", 32'(table_out), 32'h0000_0000);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(lut_pkg::OFS_CTRL, 32'h0000_0000);
    test_done();
  end
endmodule
